// File: nvsram_pkg.sv
// Purpose: shared constants for the serial nonvolatile sram core
// Assumes: 100 MHz system clock, serial link clocked by the master
// Notes:   times are in ns, cycle counts derive from the clock period
package nvsram_pkg;
  localparam int          ADDR_W          = 15;       // 32K byte locations
  localparam int          DATA_W          = 8;
  localparam int          MEM_DEPTH       = 32768;
  localparam int          CLK_PERIOD_NS   = 10;
  // nonvolatile cycle phases
  localparam int          ERASE_TIME_NS   = 4000;
  localparam int          PROG_TIME_NS    = 4000;
  localparam int          RECALL_TIME_NS  = 200;
  localparam int          HIGH_DRIVE_NS   = 30;
  localparam int          ERASE_CYC       = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PROG_CYC        = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RECALL_CYC      = (RECALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          HIGH_DRIVE_CYC  = (HIGH_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TIMER_W         = 16;
  // opcodes
  localparam logic [7:0]  OP_WRITE_EN     = 8'h06;
  localparam logic [7:0]  OP_WRITE_DIS    = 8'h04;
  localparam logic [7:0]  OP_STAT_RD      = 8'h05;
  localparam logic [7:0]  OP_STAT_WR      = 8'h01;
  localparam logic [7:0]  OP_READ         = 8'h03;
  localparam logic [7:0]  OP_WRITE        = 8'h02;
  localparam logic [7:0]  OP_STORE        = 8'h3c;
  localparam logic [7:0]  OP_RECALL       = 8'h60;
  localparam logic [7:0]  OP_SAVE_OFF     = 8'h19;
  localparam logic [7:0]  OP_SAVE_ON      = 8'h59;
  // status byte layout
  localparam int          ST_READY_BIT    = 0;
  localparam int          ST_WEL_BIT      = 1;
  localparam int          ST_BP_LO_BIT    = 2;
  localparam int          ST_BP_HI_BIT    = 3;
  localparam int          ST_PEN_BIT      = 7;
  // block protect encodings
  localparam logic [1:0]  BP_NONE         = 2'h0;
  localparam logic [1:0]  BP_QUARTER      = 2'h1;
  localparam logic [1:0]  BP_HALF         = 2'h2;
  // reset values
  localparam logic [1:0]  BP_RESET        = 2'h0;
  localparam logic        SAVE_ON_RESET   = 1'b1;
endpackage

// File: nvsram_core.sv
// Purpose: serial slave nvsram core with sram, nonvolatile copy, store and recall
// Assumes: link logic clocked by sck, frame state cleared by cs_n high
// Notes:   sram is written only in the system domain; the link reads it
//          quasi-statically, since a frame never reads what it just wrote
`timescale 1ns/100ps

// What this block does
// - 32K by 8 byte memory space
// - slave only, serial modes 0 and 3
// - write: opcode, two address bytes, data
// - burst write increments address, wraps to zero
// - read: opcode, two address bytes, data out
// - burst read increments address, wraps to zero
// - protect pin and write disable block writes
// - two bits protect none, quarter, half, all
// - hold pauses the link keeping its sequence
// - decode store, recall, save off, save on
// - busy: inhibit access, pin low, ready bit one
// - store erases then programs all cells
// - pin and power stores need prior write
// - store instruction executes unless busy, without prior write
// - supply fail with save on stores conditionally
// - store keeps memory busy for store time
// - memory access needs no wait
// - pin pulled low requests conditional store
// - one opcode per chip select period
// - msb first, sample rising, drive falling
// - recall clears sram then copies nonvolatile
module nvsram_core
  import nvsram_pkg::*;
(
  // system clock and control
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic clock_en,
  // serial link
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic hold_n,
  input  wire logic wp_n,
  output logic      so_out,
  output logic      so_oe,
  // busy/store pin, driven low and briefly high, and supply monitor
  input  wire logic busy_store_in,
  output logic      busy_store_out,
  output logic      busy_store_oe,
  input  wire logic power_fail
);

  typedef enum logic [2:0] {L_OPC, L_ADDR_HI, L_ADDR_LO, L_WDATA, L_RDATA, L_STAT_W, L_STAT_R, L_IGNORE} link_e;
  typedef enum logic [2:0] {S_IDLE, S_ERASE, S_PROG, S_CLEAR, S_COPY} nv_e;

  logic [DATA_W-1:0]  sram_mem [MEM_DEPTH];
  logic [DATA_W-1:0]  nv_mem   [MEM_DEPTH];

  // block protect decode
  function automatic logic protected_addr(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    protected_addr = (bp == BP_NONE) ? 1'b0 :
                     (bp == BP_QUARTER) ? (a[ADDR_W-1:ADDR_W-2] == 2'h3) :
                     (bp == BP_HALF) ? a[ADDR_W-1] : 1'b1;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // link domain
  logic               link_rst_reg;
  logic               busy_reg;
  link_e              lstate_reg;
  logic [2:0]         cnt_reg;
  logic [6:0]         sh_reg;
  logic [ADDR_W-1:0]  addr_reg;
  logic [DATA_W-1:0]  tx_reg;
  logic               so_reg;
  logic               so_oe_reg;
  logic               wel_reg;
  logic               pen_reg;
  logic [1:0]         bp_reg;
  logic               save_on_reg;
  logic               wr_tgl_reg;
  logic               store_tgl_reg;
  logic               recall_tgl_reg;
  logic [ADDR_W-1:0]  wr_addr_reg;
  logic [DATA_W-1:0]  wr_data_reg;
  logic               lbusy_s1_reg;
  logic               lbusy_s2_reg;
  logic               wp_s1_reg;
  logic               wp_s2_reg;

  // byte assembly and decode
  wire               byte_done = (cnt_reg == 3'h7);
  wire [7:0]         rx_byte   = {sh_reg, si};
  wire [ADDR_W-1:0]  addr_inc  = addr_reg + 15'h0001;
  wire               opc_done  = byte_done && (lstate_reg == L_OPC);
  wire               pin_lock  = !wp_s2_reg;
  wire               stat_lock = pen_reg && !wp_s2_reg;
  wire               wr_ok     = wel_reg && !pin_lock && !lbusy_s2_reg && !protected_addr(addr_reg, bp_reg);
  wire [7:0]         status    = {pen_reg, 3'h0, bp_reg, wel_reg, lbusy_s2_reg};
  wire               is_rd     = (rx_byte == OP_READ);
  wire               is_wr     = (rx_byte == OP_WRITE);

  // frame state, cleared whenever chip select goes high
  // new opcode only after cs_n high
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      lstate_reg <= L_OPC;
      cnt_reg    <= 3'h0;
      sh_reg     <= 7'h00;
      addr_reg   <= 15'h0000;
      tx_reg     <= 8'h00;
    end else if (hold_n) begin
      cnt_reg <= cnt_reg + 3'h1;
      sh_reg  <= rx_byte[6:0];
      if (byte_done) begin
        unique case (lstate_reg)
          L_OPC: begin
            lstate_reg <= (is_rd || is_wr) ? L_ADDR_HI :
                          (rx_byte == OP_STAT_WR) ? L_STAT_W :
                          (rx_byte == OP_STAT_RD) ? L_STAT_R : L_IGNORE;
            tx_reg     <= status;
            addr_reg   <= {7'h00, rx_byte};
          end
          L_ADDR_HI: begin
            lstate_reg <= L_ADDR_LO;
            addr_reg   <= {rx_byte[ADDR_W-9:0], addr_reg[7:0]};
          end
          L_ADDR_LO: begin
            if (lbusy_s2_reg) begin
              lstate_reg <= L_IGNORE;
            end else if (addr_reg[7:0] == OP_READ) begin
              lstate_reg <= L_RDATA;
              tx_reg     <= sram_mem[{addr_reg[ADDR_W-9+8:8], rx_byte}];
              addr_reg   <= {addr_reg[ADDR_W-9+8:8], rx_byte} + 15'h0001;
            end else begin
              lstate_reg <= L_WDATA;
              addr_reg   <= {addr_reg[ADDR_W-9+8:8], rx_byte};
            end
          end
          L_RDATA: begin
            tx_reg   <= sram_mem[addr_reg];
            addr_reg <= addr_inc;
          end
          L_WDATA:  addr_reg <= addr_inc;
          L_STAT_R: tx_reg <= status;
          L_STAT_W: lstate_reg <= L_IGNORE;
          L_IGNORE: lstate_reg <= L_IGNORE;
        endcase
      end
    end
  end

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_reg    <= 1'b0;
      so_oe_reg <= 1'b0;
    end else begin
      so_reg    <= tx_reg[3'h7 - cnt_reg];
      so_oe_reg <= hold_n && ((lstate_reg == L_RDATA) || (lstate_reg == L_STAT_R));
    end
  end

  // modes 0 and 3 share edge use
  assign so_out = so_reg;
  assign so_oe  = so_oe_reg;

  // persistent link state and crossings into the link clock
  always_ff @(posedge sck or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      wel_reg        <= 1'b0;
      pen_reg        <= 1'b0;
      bp_reg         <= BP_RESET;
      save_on_reg    <= SAVE_ON_RESET;
      wr_tgl_reg     <= 1'b0;
      store_tgl_reg  <= 1'b0;
      recall_tgl_reg <= 1'b0;
      wr_addr_reg    <= 15'h0000;
      wr_data_reg    <= 8'h00;
      lbusy_s1_reg   <= 1'b0;
      lbusy_s2_reg   <= 1'b0;
      wp_s1_reg      <= 1'b1;
      wp_s2_reg      <= 1'b1;
    end else begin
      lbusy_s1_reg <= busy_reg;
      lbusy_s2_reg <= lbusy_s1_reg;
      wp_s1_reg    <= wp_n;
      wp_s2_reg    <= wp_s1_reg;
      if (!cs_n && hold_n && byte_done) begin
        if (opc_done && rx_byte == OP_WRITE_EN) wel_reg <= 1'b1;
        if (opc_done && rx_byte == OP_WRITE_DIS) wel_reg <= 1'b0;
        if (opc_done && rx_byte == OP_SAVE_OFF) save_on_reg <= 1'b0;
        if (opc_done && rx_byte == OP_SAVE_ON) save_on_reg <= 1'b1;
        if (opc_done && rx_byte == OP_STORE && !lbusy_s2_reg) store_tgl_reg <= !store_tgl_reg;
        if (opc_done && rx_byte == OP_RECALL && !lbusy_s2_reg) recall_tgl_reg <= !recall_tgl_reg;
        if (lstate_reg == L_STAT_W && wel_reg && !stat_lock) begin
          pen_reg <= rx_byte[ST_PEN_BIT];
          bp_reg  <= {rx_byte[ST_BP_HI_BIT], rx_byte[ST_BP_LO_BIT]};
        end
        // data byte hands over to the array
        if (lstate_reg == L_WDATA && wr_ok) begin
          wr_addr_reg <= addr_reg;
          wr_data_reg <= rx_byte;
          wr_tgl_reg  <= !wr_tgl_reg;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain
  nv_e                nstate_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic               written_reg;
  logic [2:0]         wr_sync_reg;
  logic [2:0]         st_sync_reg;
  logic [2:0]         rc_sync_reg;
  logic [1:0]         save_sync_reg;
  logic [2:0]         pf_sync_reg;
  logic [1:0]         pin_sync_reg;
  logic [TIMER_W-1:0] hd_cnt_reg;
  logic               pin_out_reg;
  logic               pin_oe_reg;

  // event decode from synchronised toggles and pins
  wire  wr_evt     = wr_sync_reg[2] ^ wr_sync_reg[1];
  wire  st_evt     = st_sync_reg[2] ^ st_sync_reg[1];
  wire  rc_evt     = rc_sync_reg[2] ^ rc_sync_reg[1];
  wire  pf_evt     = pf_sync_reg[1] && !pf_sync_reg[2] && save_sync_reg[1];
  wire  pin_evt    = !pin_sync_reg[1] && !pin_oe_reg && (hd_cnt_reg == 16'h0000);
  wire  cond_store = (pf_evt || pin_evt) && written_reg;
  wire  go_store   = st_evt || cond_store;
  wire  timer_end  = (timer_reg == 16'h0000);
  wire  op_done    = timer_end && ((nstate_reg == S_PROG) || (nstate_reg == S_COPY));
  wire  sram_wr    = wr_evt && !busy_reg;

  // synchronisers and reset of the link domain
  always_ff @(posedge clock) begin
    link_rst_reg <= reset;
    if (reset) begin
      wr_sync_reg   <= 3'h0;
      st_sync_reg   <= 3'h0;
      rc_sync_reg   <= 3'h0;
      save_sync_reg <= 2'h0;
      pf_sync_reg   <= 3'h0;
      pin_sync_reg  <= 2'h3;
    end else if (clock_en) begin
      wr_sync_reg   <= {wr_sync_reg[1:0], wr_tgl_reg};
      st_sync_reg   <= {st_sync_reg[1:0], store_tgl_reg};
      rc_sync_reg   <= {rc_sync_reg[1:0], recall_tgl_reg};
      save_sync_reg <= {save_sync_reg[0], save_on_reg};
      pf_sync_reg   <= {pf_sync_reg[1:0], power_fail};
      pin_sync_reg  <= {pin_sync_reg[0], busy_store_in};
    end
  end

  // nonvolatile sequencer
  always_ff @(posedge clock) begin
    if (reset) begin
      nstate_reg <= S_IDLE;
      timer_reg  <= 16'h0000;
      busy_reg   <= 1'b0;
    end else if (clock_en) begin
      unique case (nstate_reg)
        S_IDLE: begin
          if (go_store) begin
            nstate_reg <= S_ERASE;
            timer_reg  <= 16'(ERASE_CYC - 1);
            busy_reg   <= 1'b1;
          end else if (rc_evt) begin
            nstate_reg <= S_CLEAR;
            busy_reg   <= 1'b1;
          end
        end
        S_ERASE: begin
          timer_reg <= timer_reg - 16'h0001;
          if (timer_end) begin
            nstate_reg <= S_PROG;
            timer_reg  <= 16'(PROG_CYC - 1);
          end
        end
        S_CLEAR: begin
          nstate_reg <= S_COPY;
          timer_reg  <= 16'(RECALL_CYC - 1);
        end
        // busy for the whole cycle time
        S_PROG, S_COPY: begin
          timer_reg <= timer_reg - 16'h0001;
          if (timer_end) begin
            nstate_reg <= S_IDLE;
            busy_reg   <= 1'b0;
          end
        end
      endcase
    end
  end

  // array writes, erase, program, clear and copy
  always_ff @(posedge clock) begin
    if (clock_en) begin
      if (sram_wr) sram_mem[wr_addr_reg] <= wr_data_reg;
      if (nstate_reg == S_ERASE && timer_end) begin
        for (int i = 0; i < MEM_DEPTH; i++) nv_mem[i] <= 8'h00;
      end
      if (nstate_reg == S_PROG && timer_end) begin
        for (int i = 0; i < MEM_DEPTH; i++) nv_mem[i] <= sram_mem[i];
      end
      if (nstate_reg == S_CLEAR) begin
        for (int i = 0; i < MEM_DEPTH; i++) sram_mem[i] <= 8'h00;
      end
      if (nstate_reg == S_COPY && timer_end) begin
        for (int i = 0; i < MEM_DEPTH; i++) sram_mem[i] <= nv_mem[i];
      end
    end
  end

  // written flag, set wins over clear
  always_ff @(posedge clock) begin
    if (reset) begin
      written_reg <= 1'b0;
    end else if (clock_en) begin
      written_reg <= sram_wr ? 1'b1 : (op_done ? 1'b0 : written_reg);
    end
  end

  // busy pin low, then a short high drive after a store
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg  <= 1'b0;
      hd_cnt_reg  <= 16'h0000;
    end else if (clock_en) begin
      if (op_done && nstate_reg == S_PROG) begin
        hd_cnt_reg <= 16'(HIGH_DRIVE_CYC);
      end else if (hd_cnt_reg != 16'h0000) begin
        hd_cnt_reg <= hd_cnt_reg - 16'h0001;
      end
      pin_out_reg <= !busy_reg && !(op_done && nstate_reg == S_PROG) ? (hd_cnt_reg > 16'h0001) : 1'b0;
      pin_oe_reg  <= (busy_reg && !op_done) || (op_done && nstate_reg == S_PROG) || (hd_cnt_reg > 16'h0001);
    end
  end

  assign busy_store_out = pin_out_reg;
  assign busy_store_oe  = pin_oe_reg;

endmodule // nvsram_core

// File: nvsram_core_asserts.sv
// Purpose: port-level checks for nvsram_core
// Assumes: busy lengths follow the package cycle counts
// Notes:   link checks run on the serial clock edges, output enable and edge checks on clock
`timescale 1ns/100ps
module nvsram_core_asserts
  import nvsram_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_en,
  // link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_out,
  input wire logic so_oe,
  // busy pin and supply
  input wire logic busy_store_in,
  input wire logic busy_store_out,
  input wire logic busy_store_oe,
  input wire logic power_fail
);
  localparam int ST_LO = ERASE_CYC + PROG_CYC - 3;
  localparam int ST_HI = ERASE_CYC + PROG_CYC + 3;
  logic       busy_low;
  logic       hi_drv;
  int         low_cnt;
  logic [4:0] n_bits;
  logic [7:0] op_seen;
  ////////////////////////////////////////
  // busy pin state
  assign busy_low = busy_store_oe & ~busy_store_out;
  assign hi_drv   = busy_store_oe & busy_store_out;
  // length of the running low phase, in enabled clock cycles
  always_ff @(posedge clock) begin
    low_cnt <= busy_low ? low_cnt + (clock_en ? 1 : 0) : 0;
  end
  // bits taken in this frame
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      n_bits <= 5'h0;
    end else if (hold_n && n_bits != 5'h1f) begin
      n_bits <= n_bits + 5'h1;
    end
  end
  // opcode of this frame
  always_ff @(posedge sck) begin
    if (hold_n && n_bits < 5'h8) begin
      op_seen <= {op_seen[6:0], si};
    end
  end
  ////////////////////////////////////////
  a_oe_in_frame: assert property (@(posedge clock) disable iff (reset)
    so_oe |-> !cs_n) else $error("output driven while deselected");
  a_so_edge: assert property (@(posedge clock) disable iff (reset)
    so_oe && $past(so_oe) && $changed(so_out) |-> !sck) else $error("output moved with clock high");
  a_read_answer: assert property (@(negedge sck) disable iff (reset)
    n_bits == 5'h18 && op_seen == OP_READ && hold_n && !busy_store_oe |=> so_oe)
    else $error("read data late");
  a_status_answer: assert property (@(negedge sck) disable iff (reset)
    n_bits == 5'h8 && op_seen == OP_STAT_RD && hold_n |=> so_oe) else $error("status late");
  a_write_silent: assert property (@(negedge sck) disable iff (reset)
    op_seen == OP_WRITE && n_bits >= 5'h8 |=> !so_oe) else $error("output during write");
  a_hold_quiet: assert property (@(negedge sck) disable iff (reset)
    !hold_n |=> !so_oe) else $error("output during hold");
  a_high_pulse: assert property (@(posedge clock) disable iff (reset)
    $past(busy_low) && hi_drv |-> ##1 hi_drv ##1 !busy_store_oe) else $error("bad high drive");
  a_store_len: assert property (@(posedge clock) disable iff (reset)
    $past(busy_low) && hi_drv |-> low_cnt >= ST_LO && low_cnt <= ST_HI) else $error("store length");
  a_recall_len: assert property (@(posedge clock) disable iff (reset)
    $fell(busy_low) && !busy_store_oe |-> low_cnt >= RECALL_CYC - 3 && low_cnt <= RECALL_CYC + 3)
    else $error("recall length");
  c_store: cover property (@(posedge clock) $past(busy_low) && hi_drv);
  c_recall: cover property (@(posedge clock) $fell(busy_low) && !busy_store_oe);
  c_read: cover property (@(negedge sck) n_bits == 5'h18 && op_seen == OP_READ);
endmodule // nvsram_core_asserts

// File: spi_master_model.sv
// Purpose: serial bus master driving the core's link
// Assumes: 30 ns serial clock, idle level chosen by mode3
// Notes:   clock stops between frames; si inverts on release
`timescale 1ns/100ps
module spi_master_model (
  // link toward the core
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  // data back from the core
  input  wire logic so
);
  bit mode3 = 0;
  int hold_at = -1;
  // idle link
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic pause();
    #5 hold_n = 1'b0;
    repeat (2) begin
      si = ~si;
      #10 sck = 1'b1;
      #15 sck = 1'b0;
    end
    #5 hold_n = 1'b1;
  endtask
  task automatic frame(input logic [7:0] tx [$], output logic [7:0] rx [$]);
    logic [7:0] b;
    rx = {};
    b = 8'h00;
    sck = mode3;
    #3 cs_n = 1'b0;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        #15 sck = 1'b0;
        si = tx[i][k];
        if (8 * i + 7 - k == hold_at) pause();
        #15 sck = 1'b1;
        b[k] = so;
      end
      rx.push_back(b);
    end
    #15 sck = mode3;
    #15 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule // spi_master_model

// File: tb_top.sv
// Purpose: self-checking bench for nvsram_core
// Assumes: master model drives the link, bench drives the rest
// Notes:   busy wire resolved here with a pull-up
`timescale 1ns/100ps
module tb_top
  import nvsram_pkg::*;
;
  typedef struct {logic [14:0] a; logic [7:0] d; bit m;} row_s;
  logic        clock = 0;
  logic        reset = 1;
  logic        clock_en = 1;
  logic        wp_n = 1;
  logic        power_fail = 0;
  logic        pin_pull = 0;
  wire         sck, cs_n, si, hold_n, so_out, so_oe, busy_store_out, busy_store_oe;
  wire         busy_store_in = busy_store_oe ? busy_store_out : ~pin_pull;
  wire         so_wire = so_oe ? so_out : clock;
  int          n_mismatch = 0;
  int          checks_done = 0;
  logic [7:0]  rx [$];
  logic [7:0]  keep [3];
  logic [14:0] pa [3] = '{15'h3fff, 15'h4000, 15'h6000};
  row_s        rows [4] = '{'{15'h0000, 8'ha5, 0}, '{15'h1234, 8'h3c, 1}, '{15'h5fff, 8'h81, 1},
                            '{15'h7fff, 8'h5a, 0}};
  always #5 clock = ~clock;
  ////////////////////////////////////////
  nvsram_core dut_u (.clock(clock), .reset(reset), .clock_en(clock_en), .sck(sck), .cs_n(cs_n),
    .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
    .busy_store_in(busy_store_in), .busy_store_out(busy_store_out),
    .busy_store_oe(busy_store_oe), .power_fail(power_fail));
  spi_master_model master_u (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so_wire));
  ////////////////////////////////////////
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic go(input logic [7:0] tx [$]);
    @(negedge clock);
    master_u.frame(tx, rx);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d [$]);
    go({OP_WRITE, 8'(a[14:8]), a[7:0], d});
  endtask
  task automatic rd(input logic [14:0] a, input int n);
    logic [7:0] tx [$];
    tx = {OP_READ, 8'(a[14:8]), a[7:0]};
    repeat (n) tx.push_back(8'h00);
    go(tx);
  endtask
  // busy pin low within a bounded wait, or never
  task automatic watch_busy(input bit exp, input string what);
    int i;
    i = 0;
    while (!(busy_store_oe === 1'b1 && busy_store_out === 1'b0) && i < 30) begin
      @(negedge clock);
      i++;
    end
    check(what, 16'(i < 30), 16'(exp));
  endtask
  // wait until the device is free
  task automatic wait_free();
    int i;
    i = 0;
    while (busy_store_oe !== 1'b0 && i < 2000) begin
      @(negedge clock);
      i++;
    end
    check("busy release", 16'(i < 2000), 16'h1);
    if (i >= 2000) report_and_stop();
  endtask
  task automatic pin_store();
    @(negedge clock);
    pin_pull = 1'b1;
    repeat (5) @(negedge clock);
    pin_pull = 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    int lim;
    repeat (20) @(negedge clock);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    check("pins idle", {busy_store_oe, so_oe}, 2'b00);
    go({OP_STAT_RD, 8'h00});
    check("status at reset", rx[1], 8'h00);
    go({OP_WRITE_EN});
    // rows across the space, both modes
    foreach (rows[r]) begin
      master_u.mode3 = rows[r].m;
      wr(rows[r].a, {rows[r].d});
      rd(rows[r].a, 1);
      check("row data", rx[3], rows[r].d);
    end
    wr(15'h7ffe, {8'h11, 8'h22, 8'h33});
    rd(15'h7ffe, 3);
    check("burst lo", rx[3], 8'h11);
    check("burst top", rx[4], 8'h22);
    check("burst wrap", rx[5], 8'h33);
    master_u.hold_at = 12;
    wr(15'h0100, {8'h77});
    master_u.hold_at = -1;
    rd(15'h0100, 1);
    check("hold", rx[3], 8'h77);
    go({OP_WRITE_DIS});
    wr(15'h0100, {8'h00});
    go({OP_WRITE_EN});
    @(negedge clock);
    wp_n = 1'b0;
    wr(15'h0100, {8'h01});
    @(negedge clock);
    wp_n = 1'b1;
    rd(15'h0100, 1);
    check("protect", rx[3], 8'h77);
    for (int bp = 0; bp < 4; bp++) begin
      go({OP_WRITE_EN});
      go({OP_STAT_WR, 8'(bp * 4)});
      go({OP_STAT_RD, 8'h00});
      check("status bp", rx[1], 8'(bp * 4 + 2));
      lim = 32768 - ((bp == 0) ? 0 : 4096 << bp);
      foreach (pa[k]) begin
        if (pa[k] < lim) keep[k] = 8'(bp * 16 + k);
        wr(pa[k], {8'(bp * 16 + k)});
        rd(pa[k], 1);
        check("block", rx[3], keep[k]);
      end
    end
    go({OP_STAT_WR, 8'h00});
    go({OP_STORE});
    watch_busy(1, "store");
    go({OP_STAT_RD, 8'h00});
    check("ready bit", rx[1][0], 1'b1);
    wr(15'h0100, {8'h99});
    wait_free();
    rd(15'h0100, 1);
    check("write while busy", rx[3], 8'h77);
    wr(15'h0100, {8'h42});
    go({OP_RECALL});
    watch_busy(1, "recall");
    wait_free();
    rd(15'h0100, 1);
    check("recall", rx[3], 8'h77);
    pin_store();
    watch_busy(0, "pin store clean");
    go({OP_STORE});
    watch_busy(1, "store clean");
    // frozen clock enable stalls the store, busy stays low
    clock_en = 1'b0;
    repeat (900) @(negedge clock);
    check("frozen busy", {busy_store_oe, busy_store_out}, 2'b10);
    clock_en = 1'b1;
    wait_free();
    go({OP_SAVE_OFF});
    wr(15'h0100, {8'h55});
    @(negedge clock);
    power_fail = 1'b1;
    watch_busy(0, "save off");
    @(negedge clock);
    power_fail = 1'b0;
    go({OP_SAVE_ON});
    @(negedge clock);
    power_fail = 1'b1;
    watch_busy(1, "save on");
    wait_free();
    power_fail = 1'b0;
    wr(15'h0100, {8'h66});
    pin_store();
    watch_busy(1, "pin store");
    wait_free();
    go({OP_RECALL});
    wait_free();
    rd(15'h0100, 1);
    check("pin stored", rx[3], 8'h66);
    report_and_stop();
  end
endmodule // tb_top

bind nvsram_core nvsram_core_asserts chk_u (.clock(clock), .reset(reset), .clock_en(clock_en),
  .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
  .busy_store_in(busy_store_in), .busy_store_out(busy_store_out), .busy_store_oe(busy_store_oe),
  .power_fail(power_fail));
